// ### design/tpc_consts.svh
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH

// Register indices; byte address is four times the index
`define TPC_EVT_IDX        16'h104d
`define TPC_CO_IDX         16'h104e

// Event pin control field positions
`define TPC_EVT_DIR_BIT    0
`define TPC_EVT_ROLE_BIT   1
`define TPC_EVT_DOUT_BIT   2
`define TPC_EVT_DIN_BIT    3

// Capture/reset and modulated pin field positions
`define TPC_CR_DIR_BIT     0
`define TPC_CR_ROLE_BIT    1
`define TPC_CR_DOUT_BIT    2
`define TPC_CR_DIN_BIT     3
`define TPC_PWM_DIR_BIT    4
`define TPC_PWM_ROLE_BIT   5
`define TPC_PWM_DOUT_BIT   6
`define TPC_PWM_DIN_BIT    7

// Reset value of every writable field
`define TPC_CTRL_RST       3'h0

// AHB-Lite encodings
`define TPC_HTRANS_NONSEQ  2'h2
`define TPC_HTRANS_SEQ     2'h3
`define TPC_HRESP_OKAY     1'h0

`endif

// ### design/tpc_pin_sync.sv
`timescale 1ns/1ps

module tpc_pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage1;

  // First stage: read only by the second stage
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      stage1 <= '0;
    else
      stage1 <= pin_in;
  end

  // Second stage: safe for logic
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      pin_sync <= '0;
    else
      pin_sync <= stage1;
  end

endmodule

// ### design/tpc_pkg.sv
package tpc_pkg;

  // One pin nibble: data out, role select, direction
  typedef struct packed {
    logic dout;
    logic role;
    logic dir;
  } tpc_nibble_t;

  // Drive of one pin
  typedef struct packed {
    logic out;
    logic oe;
  } tpc_drive_t;

  // Register selected by a bus transfer
  typedef enum logic [1:0] {
    TPC_SEL_NONE,
    TPC_SEL_EVT,
    TPC_SEL_CO
  } tpc_sel_t;

  // Data phase held from the accepted address phase
  typedef struct packed {
    logic     wr;
    tpc_sel_t sel;
  } tpc_dphase_t;

endpackage

// ### design/tpc_top.sv
// Functional notes
// - One register write sets every function of a timer pin.
// - Each timer pin owns its own four-bit nibble of a control register.
// - Event pin in GPIO mode: direction bit 0 of first register, 1 output.
// - Event pin role bit 1: 0 GPIO, 1 timer event input.
// - Event pin driven with bit 2 only when direction 1 and role 0.
// - Bit 3 of first register reads event pin level; writes ignored.
// - Bits 4 to 7 of first register are reserved.
// - Capture/reset pin direction is bit 0 of second register, 1 output.
// - Modulated pin direction is bit 4 of second register, 1 output.
// - Modulated pin driven with bit 6 only when direction 1, role 0.
// - Modulated pin data out presets the level timer toggling starts from.
// - Bit 7 of second register reads modulated pin level; writes ignored.
// - Timer role with enabled compare toggle inverts modulated pin level.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`include "tpc_consts.svh"

module tpc_top (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Event input pin
  input  wire logic        event_input_pin_in,
  output logic             event_input_pin_out,
  output logic             event_input_pin_oe,
  // Capture/counter-reset pin
  input  wire logic        capture_reset_pin_in,
  output logic             capture_reset_pin_out,
  output logic             capture_reset_pin_oe,
  // Modulated output pin
  input  wire logic        modulated_output_pin_in,
  output logic             modulated_output_pin_out,
  output logic             modulated_output_pin_oe,
  // Timer side
  input  wire logic        modulated_toggle,
  output logic             event_pin_input_value,
  output logic             capture_reset_pin_input_value,
  output logic             modulated_pin_input_value,
  output logic             event_pin_role_select,
  output logic             capture_reset_pin_role_select,
  output logic             modulated_pin_role_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  tpc_pkg::tpc_nibble_t  evt_ctrl;
  tpc_pkg::tpc_nibble_t  cr_ctrl;
  tpc_pkg::tpc_nibble_t  pwm_ctrl;
  tpc_pkg::tpc_nibble_t  next_evt_ctrl;
  tpc_pkg::tpc_nibble_t  next_cr_ctrl;
  tpc_pkg::tpc_nibble_t  next_pwm_ctrl;
  tpc_pkg::tpc_dphase_t  dphase;
  tpc_pkg::tpc_sel_t     addr_sel;
  tpc_pkg::tpc_drive_t   next_evt_drive;
  tpc_pkg::tpc_drive_t   next_cr_drive;
  tpc_pkg::tpc_drive_t   next_pwm_drive;
  logic [2:0]            pin_sync;
  logic                  addr_take;
  logic [7:0]            next_rdata;

  // GPIO output enable of one pin
  function automatic logic gpio_drives(tpc_pkg::tpc_nibble_t c);
    gpio_drives = c.dir & ~c.role;
  endfunction

  // Register select from a bus address
  function automatic tpc_pkg::tpc_sel_t decode(logic [31:0] a);
    if (a == {14'h0000, `TPC_EVT_IDX, 2'h0})
      decode = tpc_pkg::TPC_SEL_EVT;
    else if (a == {14'h0000, `TPC_CO_IDX, 2'h0})
      decode = tpc_pkg::TPC_SEL_CO;
    else
      decode = tpc_pkg::TPC_SEL_NONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers

  tpc_pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .pin_in   ({modulated_output_pin_in, capture_reset_pin_in,
                event_input_pin_in}),
    .pin_sync (pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase

  // Valid transfer accepted this cycle
  assign addr_take = hsel & hready & htrans[1];
  assign addr_sel  = decode(haddr);

  // Hold the accepted address phase for the data phase
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      dphase.wr  <= 1'b0;
      dphase.sel <= tpc_pkg::TPC_SEL_NONE;
    end
    else if (hready)
    begin
      dphase.wr  <= addr_take & hwrite;
      dphase.sel <= addr_take ? addr_sel : tpc_pkg::TPC_SEL_NONE;
    end
  end

  // Zero wait states and OKAY for every transfer, in and out of reset
  always_ff @(posedge ref_clk)
  begin
    hreadyout <= 1'b1;
    hresp     <= `TPC_HRESP_OKAY;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers, written in the data phase

  always_comb
  begin
    next_evt_ctrl = evt_ctrl;
    next_cr_ctrl  = cr_ctrl;
    next_pwm_ctrl = pwm_ctrl;
    if (dphase.wr && dphase.sel == tpc_pkg::TPC_SEL_EVT)
    begin
      next_evt_ctrl.dir  = hwdata[`TPC_EVT_DIR_BIT];
      next_evt_ctrl.role = hwdata[`TPC_EVT_ROLE_BIT];
      next_evt_ctrl.dout = hwdata[`TPC_EVT_DOUT_BIT];
    end
    if (dphase.wr && dphase.sel == tpc_pkg::TPC_SEL_CO)
    begin
      next_cr_ctrl.dir   = hwdata[`TPC_CR_DIR_BIT];
      next_cr_ctrl.role  = hwdata[`TPC_CR_ROLE_BIT];
      next_cr_ctrl.dout  = hwdata[`TPC_CR_DOUT_BIT];
      next_pwm_ctrl.dir  = hwdata[`TPC_PWM_DIR_BIT];
      next_pwm_ctrl.role = hwdata[`TPC_PWM_ROLE_BIT];
      next_pwm_ctrl.dout = hwdata[`TPC_PWM_DOUT_BIT];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      evt_ctrl <= `TPC_CTRL_RST;
      cr_ctrl  <= `TPC_CTRL_RST;
      pwm_ctrl <= `TPC_CTRL_RST;
    end
    else
    begin
      evt_ctrl <= next_evt_ctrl;
      cr_ctrl  <= next_cr_ctrl;
      pwm_ctrl <= next_pwm_ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, formed at the address phase

  // pin level, reserved read as zero
  // modulated pin level, capture pin level
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (addr_sel)
      tpc_pkg::TPC_SEL_EVT:
      begin
        next_rdata[`TPC_EVT_DIR_BIT]  = next_evt_ctrl.dir;
        next_rdata[`TPC_EVT_ROLE_BIT] = next_evt_ctrl.role;
        next_rdata[`TPC_EVT_DOUT_BIT] = next_evt_ctrl.dout;
        next_rdata[`TPC_EVT_DIN_BIT]  = pin_sync[0];
      end
      tpc_pkg::TPC_SEL_CO:
      begin
        next_rdata[`TPC_CR_DIR_BIT]   = next_cr_ctrl.dir;
        next_rdata[`TPC_CR_ROLE_BIT]  = next_cr_ctrl.role;
        next_rdata[`TPC_CR_DOUT_BIT]  = next_cr_ctrl.dout;
        next_rdata[`TPC_CR_DIN_BIT]   = pin_sync[1];
        next_rdata[`TPC_PWM_DIR_BIT]  = next_pwm_ctrl.dir;
        next_rdata[`TPC_PWM_ROLE_BIT] = next_pwm_ctrl.role;
        next_rdata[`TPC_PWM_DOUT_BIT] = next_pwm_ctrl.dout;
        next_rdata[`TPC_PWM_DIN_BIT]  = pin_sync[2];
      end
      tpc_pkg::TPC_SEL_NONE:
        next_rdata = 8'h00;
      default:
        next_rdata = 8'h00;
    endcase
  end

  // Read data stands through the data phase
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      hrdata <= 32'h0000_0000;
    else if (hready)
      hrdata <= (addr_take && !hwrite) ? {24'h00_0000, next_rdata}
                                       : 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive

  // event direction, event role, event data gated
  // capture direction, role selects, capture data
  always_comb
  begin
    next_evt_drive.oe  = gpio_drives(evt_ctrl);
    next_evt_drive.out = gpio_drives(evt_ctrl) & evt_ctrl.dout;
    next_cr_drive.oe   = gpio_drives(cr_ctrl);
    next_cr_drive.out  = gpio_drives(cr_ctrl) & cr_ctrl.dout;
  end

  // modulated direction, GPIO data, preset level
  // compare toggle inverts in timer role
  always_comb
  begin
    next_pwm_drive.oe = pwm_ctrl.role | pwm_ctrl.dir;
    if (pwm_ctrl.role)
      next_pwm_drive.out = modulated_output_pin_out ^ modulated_toggle;
    else
      next_pwm_drive.out = pwm_ctrl.dout;
  end

  // Pin outputs straight from flops
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      event_input_pin_out      <= 1'b0;
      event_input_pin_oe       <= 1'b0;
      capture_reset_pin_out    <= 1'b0;
      capture_reset_pin_oe     <= 1'b0;
      modulated_output_pin_out <= 1'b0;
      modulated_output_pin_oe  <= 1'b0;
    end
    else
    begin
      event_input_pin_out      <= next_evt_drive.out;
      event_input_pin_oe       <= next_evt_drive.oe;
      capture_reset_pin_out    <= next_cr_drive.out;
      capture_reset_pin_oe     <= next_cr_drive.oe;
      modulated_output_pin_out <= next_pwm_drive.out;
      modulated_output_pin_oe  <= next_pwm_drive.oe;
    end
  end

  // Levels and role selects toward the timer
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      event_pin_input_value         <= 1'b0;
      capture_reset_pin_input_value <= 1'b0;
      modulated_pin_input_value     <= 1'b0;
      event_pin_role_select         <= 1'b0;
      capture_reset_pin_role_select <= 1'b0;
      modulated_pin_role_select     <= 1'b0;
    end
    else
    begin
      event_pin_input_value         <= pin_sync[0];
      capture_reset_pin_input_value <= pin_sync[1];
      modulated_pin_input_value     <= pin_sync[2];
      event_pin_role_select         <= evt_ctrl.role;
      capture_reset_pin_role_select <= cr_ctrl.role;
      modulated_pin_role_select     <= pwm_ctrl.role;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // one write to the second register sets all three fields of both its pins
  a_write_all_fields: assert property (
    dphase.wr && dphase.sel == tpc_pkg::TPC_SEL_CO |=>
      pwm_ctrl == {$past(hwdata[6]), $past(hwdata[5]), $past(hwdata[4])}
      && cr_ctrl == $past(hwdata[2:0]))
    else $error("Pin control write did not set all fields");

  // event pin drive gated by direction and role
  a_evt_drive_gate: assert property (
    event_input_pin_oe == $past(evt_ctrl.dir && !evt_ctrl.role)
    && (event_input_pin_out == ($past(evt_ctrl.dir && !evt_ctrl.role)
        && $past(evt_ctrl.dout))))
    else $error("Event pin drive does not follow its nibble");

  // timer role releases the event pin within two cycles of the write
  a_evt_role_input: assert property (
    dphase.wr && dphase.sel == tpc_pkg::TPC_SEL_EVT
    && hwdata[`TPC_EVT_ROLE_BIT] |=> ##1 !event_input_pin_oe)
    else $error("Event pin still driven in timer role");

  // capture/reset pin output enable follows its nibble
  a_cr_drive_gate: assert property (
    capture_reset_pin_oe == $past(cr_ctrl.dir && !cr_ctrl.role))
    else $error("Capture pin enable does not follow its nibble");

  // modulated pin in GPIO output shows its data bit
  a_pwm_gpio_data: assert property (
    !pwm_ctrl.role && pwm_ctrl.dir |=>
      modulated_output_pin_oe && modulated_output_pin_out
      == $past(pwm_ctrl.dout))
    else $error("Modulated pin data out not driven");

  // compare toggle inverts the modulated level
  a_pwm_toggle: assert property (
    pwm_ctrl.role && modulated_toggle |=>
      modulated_output_pin_out != $past(modulated_output_pin_out))
    else $error("Modulated pin did not toggle");

  // entering timer role starts from the preset level
  a_pwm_preset: assert property (
    !pwm_ctrl.role ##1 pwm_ctrl.role && !modulated_toggle |=>
      modulated_output_pin_out == $past(pwm_ctrl.dout, 2))
    else $error("Modulated pin did not start from preset");

  // read of first register returns the pin level
  a_evt_read_level: assert property (
    addr_take && !hwrite && addr_sel == tpc_pkg::TPC_SEL_EVT |=>
      hrdata[`TPC_EVT_DIN_BIT] == $past(pin_sync[0]))
    else $error("Event pin level not returned");

  a_evt_read_rsvd: assert property (
    addr_take && !hwrite && addr_sel == tpc_pkg::TPC_SEL_EVT |=>
      hrdata[31:4] == 28'h000_0000)
    else $error("Reserved bits read nonzero");

  // read of second register returns modulated pin level
  a_pwm_read_level: assert property (
    addr_take && !hwrite && addr_sel == tpc_pkg::TPC_SEL_CO |=>
      hrdata[`TPC_PWM_DIN_BIT] == $past(pin_sync[2]))
    else $error("Modulated pin level not returned");

  // registers and the modulated pin enable clear out of reset
  a_reset_clear: assert property (
    $rose(nrst) |-> evt_ctrl == 3'h0 && cr_ctrl == 3'h0
      && pwm_ctrl == 3'h0 && !modulated_output_pin_oe)
    else $error("Control not cleared by reset");

endmodule

// ### test/timer_pin_control_tb_top.sv
`timescale 1ns/1ps
`include "tpc_consts.svh"

module timer_pin_control_tb_top;
  localparam logic [31:0] EVT_A = {14'h0, `TPC_EVT_IDX, 2'h0};
  localparam logic [31:0] CO_A  = {14'h0, `TPC_CO_IDX, 2'h0};

  logic        ref_clk;
  logic        nrst;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        modulated_toggle;
  logic [2:0]  pin;
  logic [2:0]  oe;
  logic [2:0]  out;
  logic [2:0]  ext;
  logic [2:0]  ivals;
  logic [2:0]  roles;
  logic [31:0] rd;
  logic [7:0]  w1;
  logic [7:0]  w2;
  logic [7:0]  corners [4];
  logic        pv;
  integer      seed;
  int          miscompares;
  int          check_count;

  // Clock at 40 MHz
  always #12.5 ref_clk = ~ref_clk;

  tpc_top DUT (
    .ref_clk                       (ref_clk),
    .nrst                          (nrst),
    .hsel                          (1'b1),
    .haddr                         (haddr),
    .htrans                        (htrans),
    .hwrite                        (hwrite),
    .hsize                         (hsize),
    .hwdata                        (hwdata),
    .hready                        (hreadyout),
    .hreadyout                     (hreadyout),
    .hrdata                        (hrdata),
    .hresp                         (hresp),
    .event_input_pin_in            (pin[0]),
    .event_input_pin_out           (out[0]),
    .event_input_pin_oe            (oe[0]),
    .capture_reset_pin_in          (pin[1]),
    .capture_reset_pin_out         (out[1]),
    .capture_reset_pin_oe          (oe[1]),
    .modulated_output_pin_in       (pin[2]),
    .modulated_output_pin_out      (out[2]),
    .modulated_output_pin_oe       (oe[2]),
    .modulated_toggle              (modulated_toggle),
    .event_pin_input_value         (ivals[0]),
    .capture_reset_pin_input_value (ivals[1]),
    .modulated_pin_input_value     (ivals[2]),
    .event_pin_role_select         (roles[0]),
    .capture_reset_pin_role_select (roles[1]),
    .modulated_pin_role_select     (roles[2])
  );

  tpc_board board (
    .oe  (oe),
    .out (out),
    .ext (ext),
    .pin (pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One single AHB transfer; called just after a rising edge
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [7:0] wd, output logic [31:0] r);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'h2;
    // Address phase stands until hready is seen high at an edge
    do
      @(posedge ref_clk);
    while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    // Data phase: read data taken at the edge that ends it
    do
      @(posedge ref_clk);
    while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // One-cycle compare toggle pulse
  task automatic pulse;
    modulated_toggle <= 1'b1;
    @(posedge ref_clk);
    modulated_toggle <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // Expected pins and read-back for GPIO setups of both registers
  task automatic check_pins(input logic [7:0] a, input logic [7:0] b);
    logic [2:0] eoe;
    logic [2:0] lvl;
    eoe = {b[4] & ~b[5], b[0] & ~b[1], a[0] & ~a[1]};
    lvl = (eoe & {b[6], b[2], a[2]}) | (~eoe & ext);
    chk({29'h0, oe}, {29'h0, eoe});
    chk({29'h0, out & eoe}, {29'h0, eoe & {b[6], b[2], a[2]}});
    chk({29'h0, roles}, {29'h0, b[5], b[1], a[1]});
    chk({29'h0, ivals}, {29'h0, lvl});
    ahb(1'b0, EVT_A, 8'h00, rd);
    chk(rd, {28'h0, lvl[0], a[2:0]});
    ahb(1'b0, CO_A, 8'h00, rd);
    chk(rd, {24'h0, lvl[2], b[6:4], lvl[1], b[2:0]});
  endtask

  // Cleared state after any reset
  task automatic check_cleared;
    chk({29'h0, oe}, 32'h0);
    chk({29'h0, roles}, 32'h0);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    ahb(1'b0, EVT_A, 8'h00, rd);
    chk(rd, 32'h0);
    ahb(1'b0, CO_A, 8'h00, rd);
    chk(rd, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    modulated_toggle = 1'b0;
    ext = 3'h0;
    seed = 32'hf782;
    miscompares = 0;
    check_count = 0;
    corners = '{8'hff, 8'h00, 8'h05, 8'h0d};
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    check_cleared();
    $display("reset test done");
    // Unmapped and misaligned places take no write and read zero
    for (int j = 0; j < 2; j++)
    begin
      ahb(1'b1, j ? 32'h413c : 32'h4135, 8'hff, rd);
      ahb(1'b0, j ? 32'h413c : 32'h4135, 8'h00, rd);
      chk(rd, 32'h0);
    end
    check_pins(8'h00, 8'h00);
    $display("unmapped test done");
    // Corners first, then random settings with modulated pin in GPIO role
    for (int i = 0; i < 40; i++)
    begin
      w1 = (i < 4) ? corners[i] : 8'($random(seed));
      w2 = ((i < 4) ? ~corners[i] : 8'($random(seed))) & 8'hdf;
      ext <= 3'($random(seed));
      ahb(1'b1, EVT_A, w1, rd);
      ahb(1'b1, CO_A, w2, rd);
      repeat (6) @(posedge ref_clk);
      check_pins(w1, w2);
    end
    $display("random test done");
    // Preset level, then toggling in timer role
    for (int p = 0; p < 2; p++)
    begin
      pv = p[0];
      ahb(1'b1, CO_A, {1'b0, pv, 6'h10}, rd);
      pulse();
      chk({31'h0, out[2]}, {31'h0, pv});
      ahb(1'b1, CO_A, {1'b0, pv, 6'h20}, rd);
      repeat (3) @(posedge ref_clk);
      chk({30'h0, oe[2], out[2]}, {30'h0, 1'b1, pv});
      for (int k = 1; k < 4; k++)
      begin
        pulse();
        chk({31'h0, out[2]}, {31'h0, pv ^ k[0]});
      end
      repeat (4) @(posedge ref_clk);
      ahb(1'b0, CO_A, 8'h00, rd);
      chk(rd, {24'h0, ~pv, pv, 2'h2, ext[1], 3'h0});
    end
    $display("toggle test done");
    // Reset in mid-run clears every writable field
    ext <= 3'h0;
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    check_cleared();
    $display("second reset test done");
    final_report();
  end
endmodule

// ### test/tpc_board.sv
`timescale 1ns/1ps

module tpc_board (
  input  wire logic [2:0] oe,
  input  wire logic [2:0] out,
  input  wire logic [2:0] ext,
  output logic      [2:0] pin
);
  // A driven pin shows the device level; a released one the board level
  assign pin = (oe & out) | (~oe & ext);
endmodule
